/* sysctl_pkg.sv */
package sysctl_pkg;
  localparam logic [7:0] sysctl_offset = 8'h80;
  localparam logic [31:0] sysctl_reset = 32'h0044_9060;
  localparam int step_hi = 31;
  localparam int step_lo = 30;
  localparam int merge_bit = 29;
  localparam int rsvd_bit = 28;
  localparam int clk_src_bit = 27;
  localparam int route_bit = 26;
  localparam int flag_bit = 25;
  localparam int smi_en_bit = 24;
  localparam int lock_bit = 5;
  // power switch clock divider, pci clock cycles per half period
  localparam int psw_clk_half = 8;
  localparam logic [7:0] int_pin_a = 8'h01;
  localparam logic [7:0] int_pin_b = 8'h02;
endpackage

/* sysctl_psw_clkdiv.sv */
`timescale 1ns/1ps
// derives the power switch clock from mclk by a divider
module sysctl_psw_clkdiv #(
  parameter int half_period = sysctl_pkg::psw_clk_half
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic enable,
  output logic clk_out
);
  logic [7:0] cnt_reg;

  // counter reloads each half period, stays idle while disabled
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
      clk_out <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= 8'h00;
      clk_out <= 1'b0;
    end else if (cnt_reg == 8'(half_period - 1)) begin
      cnt_reg <= 8'h00;
      clk_out <= ~clk_out;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

/* sysctl_irq_smi.sv */
`timescale 1ns/1ps
// Contract
// - 32-bit register at 80h, reset 00449060h
// - stepping field places a/b in slots
// - bit 29 merges b onto a, pin reports
// - bit 28 reads zero, ignores writes
// - bit 27 drives derived power switch clock
// - bit 26 routes to legacy line or csc
// - flag sets on power write when enabled
// - writing one clears flag, zero keeps
// - bit 24 enables smi on power writes
// - bit 5 locks subsystem id writes
module sysctl_irq_smi (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic [1:0] power_write,
  input wire logic [3:0] card_irq_in,
  output logic [3:0] serial_irq_slots,
  output logic [7:0] int_pin_func1,
  input wire logic psw_clk_in,
  output logic psw_clk_out,
  output logic psw_clk_oe,
  output logic psw_clk_seen,
  output logic subsystem_id_writable,
  output logic legacy_irq_line_two,
  output logic [1:0] card_status_change_interrupt
);
  logic [1:0] serial_irq_slot_step_reg;
  logic irq_a_b_merge_reg;
  logic power_switch_clock_source_reg;
  logic power_change_irq_route_reg;
  logic [1:0] power_write_smi_flag_reg;
  logic power_write_smi_enable_reg;
  logic subsystem_id_write_lock_reg;
  logic [23:0] low_bits_reg;
  logic [2:0] psw_sync_reg;
  logic psw_div_clk;
  logic hit;
  logic irq_a;
  logic irq_b;
  logic [3:0] lane_wr;
  logic top_byte_wr;
  logic [3:0] slot_next;
  logic [31:0] read_word;

  // byte lane write decode; every writable field of the register goes through it
  function automatic logic [3:0] lane_decode(
    input logic wr,
    input logic sel,
    input logic [3:0] be
  );
    logic [3:0] lanes;
    lanes = 4'h0;
    for (int i = 0; i < 4; i++) begin
      lanes[i] = wr && sel && be[i];
    end
    return lanes;
  endfunction

  // places the a/b card pair into the four serial frame slots, bit 0 is slot a;
  // c and d of the card are never carried by this pair
  function automatic logic [3:0] slot_place(
    input logic [1:0] step,
    input logic a,
    input logic b
  );
    logic [3:0] slots;
    slots = 4'h0;
    unique case (step)
      2'b00: slots = {1'b0, 1'b0, b, a};
      2'b01: slots = {a, b, 1'b0, 1'b0};
      2'b10: slots = {b, a, 1'b0, 1'b0};
      2'b11: slots = {a, 1'b0, 1'b0, b};
    endcase
    return slots;
  endfunction

  // both functions decode the same offset
  assign hit = (cfg_addr == sysctl_pkg::sysctl_offset);
  assign lane_wr = lane_decode(cfg_wr, hit, cfg_be);
  // byte lane 3 holds every field owned by this block except the bit 5 id lock, which sits in lane 0
  assign top_byte_wr = lane_wr[3];

  // shared control bits; software keeps to function 0, so there is no gating here:
  // a write through function 1 would change them just the same.
  // bit 28 has no storage at all, so a write to it is simply lost
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      serial_irq_slot_step_reg <=
        sysctl_pkg::sysctl_reset[sysctl_pkg::step_hi:sysctl_pkg::step_lo];
      irq_a_b_merge_reg <= sysctl_pkg::sysctl_reset[sysctl_pkg::merge_bit];
      power_switch_clock_source_reg <= sysctl_pkg::sysctl_reset[sysctl_pkg::clk_src_bit];
      power_change_irq_route_reg <= sysctl_pkg::sysctl_reset[sysctl_pkg::route_bit];
      power_write_smi_enable_reg <= sysctl_pkg::sysctl_reset[sysctl_pkg::smi_en_bit];
    end else if (top_byte_wr) begin
      serial_irq_slot_step_reg <= cfg_wdata[sysctl_pkg::step_hi:sysctl_pkg::step_lo];
      irq_a_b_merge_reg <= cfg_wdata[sysctl_pkg::merge_bit];
      power_switch_clock_source_reg <= cfg_wdata[sysctl_pkg::clk_src_bit];
      power_change_irq_route_reg <= cfg_wdata[sysctl_pkg::route_bit];
      power_write_smi_enable_reg <= cfg_wdata[sysctl_pkg::smi_en_bit];
    end
  end

  // lower bytes are only held here; their function lives elsewhere, apart from the bit 5 lock behind subsystem_id_writable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_bits_reg <= sysctl_pkg::sysctl_reset[23:0];
      subsystem_id_write_lock_reg <= sysctl_pkg::sysctl_reset[sysctl_pkg::lock_bit];
    end else begin
      if (lane_wr[0]) begin
        low_bits_reg[7:0] <= cfg_wdata[7:0];
        // the lock resets set, so the id registers start read-only
        subsystem_id_write_lock_reg <= cfg_wdata[sysctl_pkg::lock_bit];
      end
      if (lane_wr[1]) begin
        low_bits_reg[15:8] <= cfg_wdata[15:8];
      end
      if (lane_wr[2]) begin
        low_bits_reg[23:16] <= cfg_wdata[23:16];
      end
    end
  end

  // per-socket flag: set wins over a same-cycle write-one clear, so a power
  // write racing the clear is never lost; socket number equals function number
  for (genvar s = 0; s < 2; s++) begin : g_flag
    logic clr;
    logic set;
    // only a one clears; writing zero back leaves a pending flag alone
    assign clr = top_byte_wr && cfg_wdata[sysctl_pkg::flag_bit] && (cfg_func == 1'(s));
    assign set = power_write[s] && power_write_smi_enable_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        power_write_smi_flag_reg[s] <= 1'b0;
      end else if (set) begin
        power_write_smi_flag_reg[s] <= 1'b1;
      end else if (clr) begin
        power_write_smi_flag_reg[s] <= 1'b0;
      end
    end
  end

  // word as seen by the reading function: the flag follows the function, the rest is shared
  always_comb begin
    read_word = {serial_irq_slot_step_reg, irq_a_b_merge_reg, 1'b0,
                 power_switch_clock_source_reg, power_change_irq_route_reg,
                 power_write_smi_flag_reg[cfg_func], power_write_smi_enable_reg,
                 low_bits_reg[23:6], subsystem_id_write_lock_reg, low_bits_reg[4:0]};
  end

  // read data, registered; bit 28 always zero, flag of the reading function
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      if (hit) begin
        cfg_rdata <= read_word;
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  assign subsystem_id_writable = ~subsystem_id_write_lock_reg;

  // merge b onto a; c and d untouched
  assign irq_a = card_irq_in[0] | (irq_a_b_merge_reg & card_irq_in[1]);
  assign irq_b = irq_a_b_merge_reg ? 1'b0 : card_irq_in[1];
  // slots follow the stepping field, one cycle behind the card levels
  assign slot_next = slot_place(serial_irq_slot_step_reg, irq_a, irq_b);

  // slot order a,b,c,d; c and d not carried by the card pair
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      serial_irq_slots <= 4'h0;
      int_pin_func1 <= sysctl_pkg::int_pin_b;
    end else begin
      int_pin_func1 <= irq_a_b_merge_reg ? sysctl_pkg::int_pin_a : sysctl_pkg::int_pin_b;
      serial_irq_slots <= slot_next;
    end
  end

  // route smi; held while flag set, drops after clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      legacy_irq_line_two <= 1'b0;
      card_status_change_interrupt <= 2'b00;
    end else begin
      legacy_irq_line_two <= ~power_change_irq_route_reg & (|power_write_smi_flag_reg);
      card_status_change_interrupt <= {2{power_change_irq_route_reg}} & power_write_smi_flag_reg;
    end
  end

  // external clock sampled through three stages, used only when input
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      psw_sync_reg <= 3'h0;
      psw_clk_seen <= 1'b0;
    end else begin
      psw_sync_reg <= {psw_sync_reg[1:0], psw_clk_in};
      if (psw_sync_reg[1] == psw_sync_reg[2]) begin
        psw_clk_seen <= psw_sync_reg[2] & ~power_switch_clock_source_reg;
      end
    end
  end

  sysctl_psw_clkdiv #(
    .half_period(sysctl_pkg::psw_clk_half)
  ) u_div (
    .mclk(mclk),
    .arst_n(arst_n),
    .enable(power_switch_clock_source_reg),
    .clk_out(psw_div_clk)
  );

  assign psw_clk_out = psw_div_clk;
  assign psw_clk_oe = power_switch_clock_source_reg;
endmodule

/* sysctl_irq_smi_chk.sv */
`timescale 1ns/1ps
module sysctl_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic [1:0] power_write,
  input wire logic psw_clk_out,
  input wire logic psw_clk_oe,
  input wire logic subsystem_id_writable,
  input wire logic legacy_irq_line_two,
  input wire logic [1:0] card_status_change_interrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // a read of the register one edge back
  sequence rd_hit;
    $past(cfg_rd) && $past(cfg_addr) == 8'h80;
  endsequence
  // one high half period of the derived clock, then low
  sequence half_hi;
    psw_clk_out [*8] ##1 !psw_clk_out;
  endsequence
  rdata_hold_a: assert property (!$past(cfg_rd) |-> $stable(cfg_rdata))
    else $error("read data moved without a read");
  rsvd_zero_a: assert property (rd_hit |-> !cfg_rdata[28])
    else $error("reserved bit read as one");
  unmapped_zero_a: assert property ($past(cfg_rd) && $past(cfg_addr) != 8'h80 |-> cfg_rdata == 32'h0)
    else $error("other offset read nonzero");
  oe_hold_a: assert property (!$past(cfg_wr) |-> $stable(psw_clk_oe))
    else $error("clock pin direction moved");
  lock_hold_a: assert property (!$past(cfg_wr) |-> $stable(subsystem_id_writable))
    else $error("id lock moved");
  route_one_a: assert property (!(legacy_irq_line_two && |card_status_change_interrupt))
    else $error("both interrupt routes active");
  smi_cause_a: assert property ($rose(legacy_irq_line_two) && !$past(|card_status_change_interrupt)
    |-> $past(power_write, 2) != 2'h0)
    else $error("legacy line rose without power write");
  clk_half_a: assert property ($rose(psw_clk_out) && psw_clk_oe |-> half_hi)
    else $error("derived clock half period wrong");
endmodule

bind sysctl_irq_smi sysctl_chk u_chk (.*);

/* sysctl_host.sv */
`timescale 1ns/1ps
module sysctl_host (
  input wire logic mclk,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_wr = 1'b0,
  output logic cfg_rd = 1'b0,
  output logic cfg_func = 1'b0, // function 0 by default; wr and rd take fn, and the tb also writes the shared bits through function 1
  output logic [7:0] cfg_addr = 8'h00,
  output logic [3:0] cfg_be = 4'h0,
  output logic [31:0] cfg_wdata = 32'h0
);
  // one-edge write strobe; data flips after so no stale value lingers
  task automatic wr(input logic [31:0] d, input logic [3:0] be, input logic fn = 1'b0);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_func <= fn;
    cfg_addr <= 8'h80;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  // read data lands the edge after the strobe is taken
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic fn = 1'b0);
    @(posedge mclk);
    cfg_rd <= 1'b1;
    cfg_func <= fn;
    cfg_addr <= a;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    @(posedge mclk);
    d = cfg_rdata;
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_wr, cfg_rd, cfg_func, psw_clk_out, psw_clk_oe, psw_clk_seen;
  logic subsystem_id_writable, legacy_irq_line_two, psw_clk_in = 1'b0;
  logic [7:0] cfg_addr, int_pin_func1;
  logic [3:0] cfg_be, serial_irq_slots, card_irq_in = 4'h1;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  logic [1:0] card_status_change_interrupt, power_write = 2'h0;
  int n_errors = 0;
  int n_tests = 0;
  int toggles = 0;
  logic prev = 1'b0;
  always #10 mclk = ~mclk;
  sysctl_host u_host (.*);
  sysctl_irq_smi u_sysctl_irq_smi (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // power write pulse, then the fixed two-edge path to the interrupt
  task automatic pw_sock(input logic [1:0] sock);
    @(posedge mclk);
    power_write <= sock;
    @(posedge mclk);
    power_write <= 2'h0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic pw;
    pw_sock(2'h1);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    #200us;
    n_errors++;
    complete_run;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    u_host.rd(8'h80, d);
    chk(d, 32'h0044_9060);
    // pin level seen through the filter while the pin is an input
    psw_clk_in <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(psw_clk_seen, 1'b1);
    u_host.wr(32'hff00_0000, 4'h8);
    u_host.rd(8'h80, d);
    chk(d, 32'hed44_9060);
    chk(int_pin_func1, 8'h01);
    chk(psw_clk_oe, 1'b1);
    chk(psw_clk_seen, 1'b0);
    // derived clock: one toggle per half period, counted at settled falling edges
    @(negedge mclk);
    prev = psw_clk_out;
    repeat (4 * sysctl_pkg::psw_clk_half) begin
      @(negedge mclk);
      if (psw_clk_out !== prev) toggles++;
      prev = psw_clk_out;
    end
    chk(toggles, 32'd4);
    pw;
    chk(card_status_change_interrupt, 2'h1);
    u_host.wr(32'hed00_0000, 4'h8);
    u_host.rd(8'h80, d);
    chk(d, 32'hef44_9060);
    u_host.wr(32'h0a00_0000, 4'h8);
    repeat (3) @(posedge mclk);
    chk(card_status_change_interrupt, 2'h0);
    pw;
    chk(card_status_change_interrupt, 2'h0);
    u_host.wr(32'h0900_0000, 4'h8);
    pw;
    chk(legacy_irq_line_two, 1'b1);
    // socket one through function one, with socket zero still pending
    u_host.wr(32'h0d00_0000, 4'h8);
    pw_sock(2'h2);
    chk(card_status_change_interrupt, 2'h3);
    u_host.rd(8'h80, d, 1'b1);
    chk(d, 32'h0f44_9060);
    u_host.wr(32'h0f00_0000, 4'h8, 1'b1);
    repeat (3) @(posedge mclk);
    chk(card_status_change_interrupt, 2'h1);
    u_host.rd(8'h80, d);
    chk(d, 32'h0f44_9060);
    // slot stepping with only the a interrupt active
    for (int s = 0; s < 4; s++) begin
      u_host.wr({s[1:0], 6'h08, 24'h0}, 4'h8);
      repeat (2) @(posedge mclk);
      chk(serial_irq_slots, (16'h8481 >> (4 * s)) & 16'h000f);
    end
    card_irq_in <= 4'h2;
    u_host.wr(32'h2800_0000, 4'h8);
    repeat (2) @(posedge mclk);
    chk(serial_irq_slots, 4'h1);
    u_host.wr(32'h0000_0000, 4'h1);
    repeat (2) @(posedge mclk);
    chk(subsystem_id_writable, 1'b1);
    u_host.rd(8'h84, d);
    chk(d, 32'h0);
    // reset in mid-run: flags, routes and the lock return to their reset state
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    chk(legacy_irq_line_two, 1'b0);
    chk(int_pin_func1, 8'h02);
    u_host.rd(8'h80, d);
    chk(d, 32'h0044_9060);
    complete_run;
  end
endmodule
